// >>> dv/eawsc_assertions.sv
// Port-level checker of the external area wait-state controller
`timescale 1ns/10ps
`include "eawsc_regs.vh"

module eawsc_assertions
(
    // Clock, reset and standby
    input wire        aclk,
    input wire        aresetn,
    input wire        hw_standby,
    // Register bus handshakes
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    // Bus cycle
    input wire        req_valid,
    input wire        req_ready,
    input wire [2:0]  cyc_state,
    input wire        cyc_ext,
    input wire        cyc_three,
    input wire        cyc_wait,
    input wire        cyc_done
);
    // Standby restarts the cycle machine, so it masks the checks like reset
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || hw_standby);

    sequence s_req_taken;
        req_valid && req_ready;
    endsequence

    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    chk_req_start: assert property (s_req_taken |=>
        (cyc_state == `EAWSC_ST_T1 || cyc_state == `EAWSC_ST_INT))
        else $error("bus cycle did not start after request");
    chk_first_second: assert property (cyc_state == `EAWSC_ST_T1 |=> cyc_state == `EAWSC_ST_S2)
        else $error("first state not followed by second state");
    chk_two_state_end: assert property (
        cyc_state == `EAWSC_ST_S2 && cyc_ext && !cyc_three |=>
        cyc_state == `EAWSC_ST_IDLE && cyc_done)
        else $error("two-state access did not end after second state");
    chk_wait_three: assert property (
        cyc_state == `EAWSC_ST_WT |-> cyc_three && cyc_ext && cyc_wait)
        else $error("wait state outside an external three-state access");
    chk_onchip_fixed: assert property (
        s_req_taken ##1 cyc_state == `EAWSC_ST_INT |=>
        cyc_state == `EAWSC_ST_INT ##1 (cyc_done && cyc_state == `EAWSC_ST_IDLE))
        else $error("on-chip access not two states");
    chk_last_done: assert property (cyc_state == `EAWSC_ST_T3 |=>
        cyc_done && cyc_state == `EAWSC_ST_IDLE)
        else $error("no completion after last state");
    chk_done_pulse: assert property (cyc_done |=> !cyc_done)
        else $error("completion longer than one cycle");
    chk_ready_idle: assert property (req_ready == (cyc_state == `EAWSC_ST_IDLE))
        else $error("request ready does not match idle");
    chk_wr_answer: assert property (s_both_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
endmodule

bind eawsc_top eawsc_assertions chk_u
(
    .aclk(aclk), .aresetn(aresetn), .hw_standby(hw_standby),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .req_valid(req_valid), .req_ready(req_ready), .cyc_state(cyc_state), .cyc_ext(cyc_ext),
    .cyc_three(cyc_three), .cyc_wait(cyc_wait), .cyc_done(cyc_done)
);

// >>> dv/eawsc_ext_dev.sv
// Model of an external device that stretches accesses with the stall input
`timescale 1ns/10ps
`include "eawsc_regs.vh"

module eawsc_ext_dev
(
    // Clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    // Bus cycle progress
    input  wire [2:0] cyc_state,
    input  wire       cyc_ext,
    // States to hold stall low, counted from the second state
    input  wire [2:0] hold_states,
    output wire       stall_n
);
    reg  [2:0] cnt_q;
    wire       busy = cyc_ext && (cyc_state == `EAWSC_ST_S2 || cyc_state == `EAWSC_ST_WT);

    always @(posedge aclk)
    begin
        if (!aresetn || !busy)
            cnt_q <= 3'h0;
        else if (cnt_q != 3'h7)
            cnt_q <= cnt_q + 3'h1;
    end

    // Low from the second state until ready; released line is pulled up
    assign stall_n = !(busy && cnt_q < hold_states);
endmodule

// >>> dv/tb_top.sv
// Self-checking testbench of the external area wait-state controller
`timescale 1ns/10ps
`include "eawsc_regs.vh"

module tb_top;
    reg         aclk, aresetn, hw_standby, req_valid, req_write;
    reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    reg  [17:0] s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata;
    reg  [3:0]  s_axi_wstrb;
    reg  [2:0]  s_axi_awprot, s_axi_arprot, hold_states;
    reg  [23:0] req_addr;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        req_ready, stall_n, cyc_ext, cyc_three, cyc_write, cyc_wait, cyc_done;
    wire [2:0]  cyc_state, cyc_area;
    integer     n_errors, check_count, lat, i, j, k;
    reg  [31:0] rd;
    reg  [1:0]  rsp;
    localparam [17:0] ASC = {`EAWSC_IDX_ASC, 2'b00};
    localparam [17:0] SCR = {`EAWSC_IDX_SCR, 2'b00};
    localparam [17:0] ASE = {`EAWSC_IDX_ASE, 2'b00};
    localparam [17:0] SYS = {`EAWSC_IDX_SYS, 2'b00};

    eawsc_top dut_u
    (
        .aclk(aclk), .aresetn(aresetn), .hw_standby(hw_standby),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr),
        .req_write(req_write), .stall_n(stall_n), .cyc_state(cyc_state),
        .cyc_area(cyc_area), .cyc_ext(cyc_ext), .cyc_three(cyc_three),
        .cyc_write(cyc_write), .cyc_wait(cyc_wait), .cyc_done(cyc_done)
    );

    eawsc_ext_dev ext_u
    (
        .aclk(aclk), .aresetn(aresetn), .cyc_state(cyc_state), .cyc_ext(cyc_ext),
        .hold_states(hold_states), .stall_n(stall_n)
    );

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("Error at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task end_of_test;
        if (n_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Response ready lines stay high between transfers, so no edge sees them toggled twice
    task wr(input [17:0] a, input [7:0] d, input [3:0] strb, output [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask

    task rdr(input [17:0] a, output [31:0] d, output [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    // Cycles from the taking edge to the edge that sees completion
    task cyc(input [23:0] a, output integer n);
        req_addr <= a;
        req_write <= a[0];
        req_valid <= 1'b1;
        @(posedge aclk);
        req_valid <= 1'b0;
        n = 0;
        do
        begin
            @(posedge aclk);
            n = n + 1;
        end
        while (!cyc_done);
        chk(cyc_write, a[0]);
    endtask

    task chk_defaults;
        rdr(ASC, rd, rsp);
        chk(rd, 32'h0000_00FF);
        rdr(SCR, rd, rsp);
        chk(rd, 32'h0000_00F3);
        rdr(ASE, rd, rsp);
        chk(rd, 32'h0000_00FF);
        chk(rsp, 2'h0);
    endtask

    // Total latency; pin mode 1 with zero count reduces to max(0, n) = pin mode 0
    function integer lat_exp(input ast, input wce, input [1:0] m, input [1:0] c,
                             input integer n);
        integer w;
        w = 0;
        if (!wce) w = n;
        else if (m == `EAWSC_WM_PROG) w = c;
        else if (m == `EAWSC_WM_PIN1) w = (n > c) ? n : c;
        else if (m == `EAWSC_WM_AUTO) w = (n > 0) ? c : 0;
        lat_exp = ast ? 4 + w : 3;
    endfunction

    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    initial
    begin
        repeat (40000) @(posedge aclk);
        n_errors = n_errors + 1;
        end_of_test;
    end

    initial
    begin
        n_errors = 0;
        check_count = 0;
        {aresetn, hw_standby, req_valid, req_write, s_axi_awvalid, s_axi_wvalid} = 6'h00;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 72'h00_0000_0000_0000_0000;
        {s_axi_awprot, s_axi_arprot, hold_states, req_addr} = 33'h0_0000_0000;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk_defaults;
        cyc(24'h00_0040, lat);
        chk(lat, 7);
        cyc(24'h0F_F800, lat);
        chk(lat, 3);
        chk(cyc_ext, 1'b0);
        wr(SYS, 8'h00, 4'h1, rsp);
        cyc(24'h0F_F800, lat);
        chk({cyc_ext, cyc_area, lat[3:0]}, 8'hF7);
        rdr({`EAWSC_IDX_STAT, 2'b00}, rd, rsp);
        chk(rd, 32'h0000_00F8);
        cyc(24'h0F_FF10, lat);
        chk(lat, 3);
        for (j = 0; j < 2; j = j + 1)
        begin
            wr(SYS, {6'h00, j[0], 1'b1}, 4'h1, rsp);
            for (i = 0; i < 8; i = i + 1)
            begin
                cyc(j[0] ? {i[2:0], 21'h00_0100} : {4'h0, i[2:0], 17'h0_0100}, lat);
                chk(cyc_area, i[2:0]);
            end
        end
        wr(SYS, 8'h01, 4'h1, rsp);
        wr(SCR, 8'h00, 4'h0, rsp);
        rdr(SCR, rd, rsp);
        chk(rd, 32'h0000_00F3);
        for (i = 0; i < 4; i = i + 1)
        begin
            // Area 4 gets the opposite per-area bits to area 3
            wr(ASC, i[0] ? 8'h08 : 8'hF7, 4'h1, rsp);
            wr(ASE, i[1] ? 8'h08 : 8'hF7, 4'h1, rsp);
            for (j = 0; j < 16; j = j + 1)
            begin
                wr(SCR, {4'h0, j[3:0]}, 4'h1, rsp);
                rdr(SCR, rd, rsp);
                chk(rd, {24'h00_0000, 4'hF, j[3:0]});
                for (k = 0; k < 5; k = k + 2)
                begin
                    hold_states <= k[2:0];
                    cyc(24'h06_0010, lat);
                    chk(lat, lat_exp(i[0], i[1], j[3:2], j[1:0], k));
                    cyc(24'h08_0010, lat);
                    chk(lat, lat_exp(!i[0], !i[1], j[3:2], j[1:0], k));
                end
            end
        end
        hold_states <= 3'h0;
        wr(18'h0_0010, 8'h55, 4'h1, rsp);
        chk(rsp, `EAWSC_RESP_ERR);
        rdr(18'h0_0010, rd, rsp);
        chk({rd, 2'b00, rsp}, {32'h0000_0000, 2'b00, `EAWSC_RESP_ERR});
        hw_standby <= 1'b1;
        repeat (2) @(posedge aclk);
        hw_standby <= 1'b0;
        @(posedge aclk);
        chk_defaults;
        end_of_test;
    end
endmodule

// >>> rtl/eawsc_area_dec.v
// Address to area and on-chip window decoder
`timescale 1ns/10ps
`include "eawsc_regs.vh"

module eawsc_area_dec
(
    // Address and configuration
    input  wire [23:0] addr,
    input  wire        mode_16m,
    input  wire        sram_en,
    // Decode result
    output wire [2:0]  area,
    output wire        on_chip
);
    wire        top_blk;
    wire [15:0] low16;

    assign low16   = addr[15:0];
    // Top 64 kbytes of the active space
    assign top_blk = mode_16m ? (addr[23:16] == 8'hFF)
                              : (addr[19:16] == 4'hF);
    assign area    = mode_16m ? addr[23:21] : addr[19:17];
    // RAM window turns external when disabled; I/O window is always on-chip
    assign on_chip = top_blk
                   & ((low16 >= `EAWSC_IO_LO)
                   | (sram_en & (low16 >= `EAWSC_RAM_LO)
                      & (low16 <= `EAWSC_RAM_HI)));
endmodule

// >>> rtl/eawsc_mode_sel.v
// Resolves the effective wait mode of one area
`timescale 1ns/10ps
`include "eawsc_regs.vh"

module eawsc_mode_sel
(
    // Area settings
    input  wire       three_state,
    input  wire       stall_en,
    input  wire [1:0] wm,
    input  wire [1:0] count,
    // Effective mode
    output reg  [2:0] eff
);
    always @*
    begin
        eff = `EAWSC_EM_NONE;
        if (three_state)
        begin
            if (!stall_en)
                eff = `EAWSC_EM_PIN0;
            else
            begin
                case (wm)
                    `EAWSC_WM_PROG: eff = `EAWSC_EM_PROG;
                    `EAWSC_WM_NONE: eff = `EAWSC_EM_NONE;
                    `EAWSC_WM_PIN1: eff = (count == 2'h0) ? `EAWSC_EM_PIN0
                                                          : `EAWSC_EM_PIN1;
                    `EAWSC_WM_AUTO: eff = `EAWSC_EM_AUTO;
                    default:        eff = `EAWSC_EM_NONE;
                endcase
            end
        end
    end
endmodule

// >>> rtl/eawsc_regs.vh
// Constants of the external area wait-state controller
`ifndef EAWSC_REGS_VH
`define EAWSC_REGS_VH

// Register indices, byte address is four times index
`define EAWSC_IDX_ASC     16'hFFED
`define EAWSC_IDX_SCR     16'hFFEE
`define EAWSC_IDX_ASE     16'hFFEF
`define EAWSC_IDX_SYS     16'hFFE0
`define EAWSC_IDX_STAT    16'hFFE1
`define EAWSC_AW          18

// Register select codes
`define EAWSC_SEL_NONE    3'h0
`define EAWSC_SEL_ASC     3'h1
`define EAWSC_SEL_SCR     3'h2
`define EAWSC_SEL_ASE     3'h3
`define EAWSC_SEL_SYS     3'h4
`define EAWSC_SEL_STAT    3'h5

// Reset values
`define EAWSC_RST_ASC     8'hFF
`define EAWSC_RST_SCR     8'hF3
`define EAWSC_RST_ASE     8'hFF
`define EAWSC_RST_SYS     8'h01
`define EAWSC_SCR_FIXED   8'hF0

// Field positions
`define EAWSC_MODE_HI     3
`define EAWSC_MODE_LO     2
`define EAWSC_CNT_HI      1
`define EAWSC_CNT_LO      0
`define EAWSC_SYS_SRAM    0
`define EAWSC_SYS_16M     1

// Global stall mode field codes
`define EAWSC_WM_PROG     2'h0
`define EAWSC_WM_NONE     2'h1
`define EAWSC_WM_PIN1     2'h2
`define EAWSC_WM_AUTO     2'h3

// Effective per-access modes
`define EAWSC_EM_NONE     3'h0
`define EAWSC_EM_PIN0     3'h1
`define EAWSC_EM_PROG     3'h2
`define EAWSC_EM_PIN1     3'h3
`define EAWSC_EM_AUTO     3'h4

// Bus states
`define EAWSC_ST_IDLE     3'h0
`define EAWSC_ST_T1       3'h1
`define EAWSC_ST_S2       3'h2
`define EAWSC_ST_WT       3'h3
`define EAWSC_ST_T3       3'h4
`define EAWSC_ST_INT      3'h5

// Top-of-space windows, low 16 address bits
`define EAWSC_RAM_LO      16'hF000
`define EAWSC_RAM_HI      16'hFEFF
`define EAWSC_IO_LO       16'hFF00
`define EAWSC_INT_STATES  2'h2

// AXI responses
`define EAWSC_RESP_OK     2'h0
`define EAWSC_RESP_ERR    2'h2

`endif

// >>> rtl/eawsc_top.v
// External area decoder and wait-state controller with AXI4-Lite registers
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "eawsc_regs.vh"

module eawsc_top
(
    // Clock and reset
    input  wire                  aclk,
    input  wire                  aresetn,
    // Hardware standby, reinitialises settings
    input  wire                  hw_standby,
    // AXI4-Lite write address
    input  wire                  s_axi_awvalid,
    output wire                  s_axi_awready,
    input  wire [`EAWSC_AW-1:0]  s_axi_awaddr,
    input  wire [2:0]            s_axi_awprot,
    // AXI4-Lite write data
    input  wire                  s_axi_wvalid,
    output wire                  s_axi_wready,
    input  wire [31:0]           s_axi_wdata,
    input  wire [3:0]            s_axi_wstrb,
    // AXI4-Lite write response
    output wire                  s_axi_bvalid,
    input  wire                  s_axi_bready,
    output wire [1:0]            s_axi_bresp,
    // AXI4-Lite read address
    input  wire                  s_axi_arvalid,
    output wire                  s_axi_arready,
    input  wire [`EAWSC_AW-1:0]  s_axi_araddr,
    input  wire [2:0]            s_axi_arprot,
    // AXI4-Lite read data
    output wire                  s_axi_rvalid,
    input  wire                  s_axi_rready,
    output wire [31:0]           s_axi_rdata,
    output wire [1:0]            s_axi_rresp,
    // Bus cycle request
    input  wire                  req_valid,
    output wire                  req_ready,
    input  wire [23:0]           req_addr,
    input  wire                  req_write,
    // External stall input, active low
    input  wire                  stall_n,
    // Bus cycle progress
    output wire [2:0]            cyc_state,
    output wire [2:0]            cyc_area,
    output wire                  cyc_ext,
    output wire                  cyc_three,
    output wire                  cyc_write,
    output wire                  cyc_wait,
    output wire                  cyc_done
);

    // Byte address to register select, shared by both channels
    function [2:0] eawsc_sel;
        input [`EAWSC_AW-1:0] a;
        begin
            eawsc_sel = `EAWSC_SEL_NONE;
            if (a[1:0] == 2'h0)
            begin
                case (a[`EAWSC_AW-1:2])
                    `EAWSC_IDX_ASC:  eawsc_sel = `EAWSC_SEL_ASC;
                    `EAWSC_IDX_SCR:  eawsc_sel = `EAWSC_SEL_SCR;
                    `EAWSC_IDX_ASE:  eawsc_sel = `EAWSC_SEL_ASE;
                    `EAWSC_IDX_SYS:  eawsc_sel = `EAWSC_SEL_SYS;
                    `EAWSC_IDX_STAT: eawsc_sel = `EAWSC_SEL_STAT;
                    default:         eawsc_sel = `EAWSC_SEL_NONE;
                endcase
            end
        end
    endfunction

    // Settings registers
    reg  [7:0]  asc_q;
    reg  [7:0]  scr_q;
    reg  [7:0]  ase_q;
    reg  [7:0]  sys_q;

    // AXI slave state
    reg                  aw_full_q;
    reg  [`EAWSC_AW-1:0] aw_addr_q;
    reg                  w_full_q;
    reg  [7:0]           w_data_q;
    reg                  w_strb_q;
    reg                  bvalid_q;
    reg  [1:0]           bresp_q;
    reg                  rvalid_q;
    reg  [31:0]          rdata_q;
    reg  [1:0]           rresp_q;

    // Bus cycle state
    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [2:0]  area_q;
    reg         ext_q;
    reg         three_q;
    reg         write_q;
    reg  [2:0]  eff_q;
    reg  [1:0]  cnt_set_q;
    reg  [1:0]  cnt_q;
    reg  [1:0]  cnt_d;
    reg         pin_q;
    reg         pin_d;
    reg         done_q;
    reg  [1:0]  int_q;

    wire        aw_hs;
    wire        w_hs;
    wire        ar_hs;
    wire        do_wr;
    wire [2:0]  wr_sel;
    wire [2:0]  rd_sel;
    wire        init;
    wire [2:0]  dec_area;
    wire        dec_on_chip;
    wire [2:0]  dec_eff;
    wire        dec_three;
    wire        req_hs;
    wire [1:0]  wm;
    wire [1:0]  wcount;
    wire [1:0]  cnt_m1;

    assign aw_hs  = s_axi_awvalid & s_axi_awready;
    assign w_hs   = s_axi_wvalid & s_axi_wready;
    assign ar_hs  = s_axi_arvalid & s_axi_arready;
    assign do_wr  = aw_full_q & w_full_q & ~bvalid_q;
    assign wr_sel = eawsc_sel(aw_addr_q);
    assign rd_sel = eawsc_sel(s_axi_araddr);
    // Software standby has no input here, so settings simply hold
    assign init   = ~aresetn | hw_standby;

    assign s_axi_awready = ~aw_full_q & ~bvalid_q;
    assign s_axi_wready  = ~w_full_q & ~bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // Write address and data may arrive in either order
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            aw_addr_q <= {`EAWSC_AW{1'b0}};
            w_full_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_strb_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `EAWSC_RESP_OK;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_hs)
            begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_strb_q <= s_axi_wstrb[0];
            end
            if (do_wr)
            begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (wr_sel == `EAWSC_SEL_NONE) ? `EAWSC_RESP_ERR
                                                         : `EAWSC_RESP_OK;
            end
            else if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    // Settings, written only through the low byte lane
    always @(posedge aclk)
    begin
        if (init)
        begin
            asc_q <= `EAWSC_RST_ASC;
            scr_q <= `EAWSC_RST_SCR;
            ase_q <= `EAWSC_RST_ASE;
            sys_q <= `EAWSC_RST_SYS;
        end
        else if (do_wr && w_strb_q)
        begin
            case (wr_sel)
                `EAWSC_SEL_ASC: asc_q <= w_data_q;
                `EAWSC_SEL_SCR: scr_q <= `EAWSC_SCR_FIXED | w_data_q;
                `EAWSC_SEL_ASE: ase_q <= w_data_q;
                `EAWSC_SEL_SYS: sys_q <= {6'h00, w_data_q[1:0]};
                default:        ;
            endcase
        end
    end

    // Read channel, one outstanding read
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `EAWSC_RESP_OK;
        end
        else if (ar_hs)
        begin
            rvalid_q <= 1'b1;
            rresp_q  <= `EAWSC_RESP_OK;
            case (rd_sel)
                `EAWSC_SEL_ASC:  rdata_q <= {24'h00_0000, asc_q};
                `EAWSC_SEL_SCR:  rdata_q <= {24'h00_0000, scr_q};
                `EAWSC_SEL_ASE:  rdata_q <= {24'h00_0000, ase_q};
                `EAWSC_SEL_SYS:  rdata_q <= {24'h00_0000, sys_q};
                `EAWSC_SEL_STAT: rdata_q <= {24'h00_0000, ext_q,
                                             three_q, area_q,
                                             state_q};
                default:
                begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= `EAWSC_RESP_ERR;
                end
            endcase
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
    end

    eawsc_area_dec u_dec
    (
        .addr     (req_addr),
        .mode_16m (sys_q[`EAWSC_SYS_16M]),
        .sram_en  (sys_q[`EAWSC_SYS_SRAM]),
        .area     (dec_area),
        .on_chip  (dec_on_chip)
    );

    assign wm        = scr_q[`EAWSC_MODE_HI:`EAWSC_MODE_LO];
    assign wcount    = scr_q[`EAWSC_CNT_HI:`EAWSC_CNT_LO];
    assign dec_three = asc_q[dec_area];

    eawsc_mode_sel u_mode
    (
        .three_state (dec_three),
        .stall_en    (ase_q[dec_area]),
        .wm          (wm),
        .count       (wcount),
        .eff         (dec_eff)
    );

    assign req_ready = (state_q == `EAWSC_ST_IDLE);
    assign req_hs    = req_valid & req_ready;
    assign cnt_m1    = cnt_set_q - 2'h1;

    // Next bus state; stall_n is sampled at the edge closing the second or a stall state
    always @*
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        pin_d   = pin_q;
        case (state_q)
            `EAWSC_ST_IDLE:
            begin
                if (req_hs)
                    state_d = dec_on_chip ? `EAWSC_ST_INT : `EAWSC_ST_T1;
            end
            `EAWSC_ST_T1:
                state_d = `EAWSC_ST_S2;
            `EAWSC_ST_S2:
            begin
                state_d = three_q ? `EAWSC_ST_T3 : `EAWSC_ST_IDLE;
                cnt_d   = 2'h0;
                pin_d   = 1'b0;
                case (eff_q)
                    `EAWSC_EM_PIN0:
                    begin
                        if (!stall_n)
                        begin
                            state_d = `EAWSC_ST_WT;
                            pin_d   = 1'b1;
                        end
                    end
                    `EAWSC_EM_PROG:
                    begin
                        if (cnt_set_q != 2'h0)
                        begin
                            state_d = `EAWSC_ST_WT;
                            cnt_d   = cnt_m1;
                        end
                    end
                    `EAWSC_EM_PIN1:
                    begin
                        state_d = `EAWSC_ST_WT;
                        cnt_d   = cnt_m1;
                        pin_d   = 1'b1;
                    end
                    `EAWSC_EM_AUTO:
                    begin
                        if (!stall_n && cnt_set_q != 2'h0)
                        begin
                            state_d = `EAWSC_ST_WT;
                            cnt_d   = cnt_m1;
                        end
                    end
                    default:
                        state_d = three_q ? `EAWSC_ST_T3 : `EAWSC_ST_IDLE;
                endcase
            end
            `EAWSC_ST_WT:
            begin
                if (cnt_q != 2'h0)
                    cnt_d = cnt_q - 2'h1;
                else if (!(pin_q && !stall_n))
                    state_d = `EAWSC_ST_T3;
            end
            `EAWSC_ST_T3:
                state_d = `EAWSC_ST_IDLE;
            `EAWSC_ST_INT:
            begin
                if (int_q == `EAWSC_INT_STATES - 2'h1)
                    state_d = `EAWSC_ST_IDLE;
            end
            default:
                state_d = `EAWSC_ST_IDLE;
        endcase
    end

    // Area settings are captured once per bus cycle, at its start
    always @(posedge aclk)
    begin
        if (init)
        begin
            state_q   <= `EAWSC_ST_IDLE;
            area_q    <= 3'h0;
            ext_q     <= 1'b0;
            three_q   <= 1'b0;
            write_q   <= 1'b0;
            eff_q     <= `EAWSC_EM_NONE;
            cnt_set_q <= 2'h0;
            cnt_q     <= 2'h0;
            pin_q     <= 1'b0;
            done_q    <= 1'b0;
            int_q     <= 2'h0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            pin_q   <= pin_d;
            done_q  <= (state_q != `EAWSC_ST_IDLE)
                     & (state_d == `EAWSC_ST_IDLE);
            if (req_hs)
            begin
                area_q    <= dec_area;
                ext_q     <= ~dec_on_chip;
                three_q   <= dec_three & ~dec_on_chip;
                write_q   <= req_write;
                eff_q     <= dec_eff;
                cnt_set_q <= wcount;
                int_q     <= 2'h0;
            end
            else if (state_q == `EAWSC_ST_INT)
                int_q <= int_q + 2'h1;
        end
    end

    assign cyc_state = state_q;
    assign cyc_area  = area_q;
    assign cyc_ext   = ext_q;
    assign cyc_three = three_q;
    assign cyc_write = write_q;
    assign cyc_wait  = (state_q == `EAWSC_ST_WT);
    assign cyc_done  = done_q;

endmodule
